// >>> piot_pkg.sv
// constants and types for the phase instantaneous overcurrent trip block
// Behaviour
// (R1) each phase trips without added delay when its selected value exceeds the threshold
// (R2) operation off, peak value or fundamental value; off after reset
// (R3) start threshold in percent, 20 to 3000 in steps of 1, default 200
// (R4) block input held high forces all phase trips and general trip low
// (R5) doubling input held high compares against twice the start threshold
// (R6) three separate phase trip outputs, each from its own phase only
// (R7) decision stage derives one general trip from the three phase trips
// (R8) general trip is the logical OR of the three phase trips
// (R9) every sample re-evaluates each phase; trip drops once value no longer exceeds
package piot_pkg;

    typedef enum logic [1:0] {
        PIOT_MODE_OFF = 2'h0,
        PIOT_MODE_PEAK = 2'h1,
        PIOT_MODE_FUND = 2'h2
    } piot_mode_t;

    localparam int PIOT_PHASES = 3;
    localparam int PIOT_START_W = 12;
    localparam int PIOT_THR_W = PIOT_START_W + 1;
    localparam logic [PIOT_START_W-1:0] PIOT_START_MIN = 12'h014;
    localparam logic [PIOT_START_W-1:0] PIOT_START_MAX = 12'hBB8;
    localparam logic [PIOT_START_W-1:0] PIOT_START_RESET = 12'h0C8;

    localparam logic [7:0] PIOT_OFS_CTRL = 8'h00;
    localparam logic [7:0] PIOT_OFS_START = 8'h04;
    localparam logic [7:0] PIOT_OFS_STATUS = 8'h08;
    localparam logic [7:0] PIOT_OFS_MEAS_A = 8'h0C;
    localparam logic [7:0] PIOT_OFS_MEAS_B = 8'h10;
    localparam logic [7:0] PIOT_OFS_MEAS_C = 8'h14;

    localparam int PIOT_CTRL_MODE_LSB = 0;
    localparam int PIOT_CTRL_MODE_W = 2;
    localparam int PIOT_STAT_TRIP_LSB = 0;
    localparam int PIOT_STAT_GEN_BIT = 3;
    localparam int PIOT_STAT_BLK_BIT = 4;
    localparam int PIOT_STAT_DBL_BIT = 5;

    localparam logic [1:0] PIOT_RESP_OKAY = 2'h0;
    localparam logic [1:0] PIOT_RESP_SLVERR = 2'h2;

endpackage

// >>> piot_phase_compare.sv
// one phase: picks the measured quantity and compares it with the threshold
`timescale 1ns/1ps
module piot_phase_compare #(
    parameter int MEAS_W = 16
) (
    input piot_pkg::piot_mode_t mode,
    input logic [MEAS_W-1:0] peakValue,
    input logic [MEAS_W-1:0] fundValue,
    input logic [piot_pkg::PIOT_THR_W-1:0] threshold,
    output logic [MEAS_W-1:0] selValue,
    output logic overThreshold
);
    localparam int CMP_W = (MEAS_W > piot_pkg::PIOT_THR_W) ? MEAS_W : piot_pkg::PIOT_THR_W;

    logic [CMP_W-1:0] valWide;
    logic [CMP_W-1:0] thrWide;

    always_comb begin
        case (mode)
            piot_pkg::PIOT_MODE_PEAK: begin
                selValue = peakValue; // R2
            end
            piot_pkg::PIOT_MODE_FUND: begin
                selValue = fundValue; // R2
            end
            default: begin
                selValue = '0;
            end
        endcase
        valWide = CMP_W'(selValue);
        thrWide = CMP_W'(threshold);
        // strictly above; equal does not trip
        overThreshold = (mode != piot_pkg::PIOT_MODE_OFF) && (valWide > thrWide); // R1
    end
endmodule

// >>> piot_trip_top.sv
// phase instantaneous overcurrent trip with AXI4-Lite settings and status
//
// Added by the designer: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
module piot_trip_top #(
    parameter int MEAS_W = 16,
    parameter int ADDR_W = 8
) (
    input logic clk_sys,
    input logic rst_b,
    input logic [ADDR_W-1:0] s_axi_awaddr,
    input logic [2:0] s_axi_awprot,
    input logic s_axi_awvalid,
    output logic s_axi_awready,
    input logic [31:0] s_axi_wdata,
    input logic [3:0] s_axi_wstrb,
    input logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input logic s_axi_bready,
    input logic [ADDR_W-1:0] s_axi_araddr,
    input logic [2:0] s_axi_arprot,
    input logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input logic s_axi_rready,
    input logic sample_valid,
    input logic [MEAS_W-1:0] phase_a_peak_value,
    input logic [MEAS_W-1:0] phase_b_peak_value,
    input logic [MEAS_W-1:0] phase_c_peak_value,
    input logic [MEAS_W-1:0] phase_a_fundamental_rms,
    input logic [MEAS_W-1:0] phase_b_fundamental_rms,
    input logic [MEAS_W-1:0] phase_c_fundamental_rms,
    input logic function_block_in,
    input logic threshold_double_in,
    output logic phase_a_trip_out,
    output logic phase_b_trip_out,
    output logic phase_c_trip_out,
    output logic general_trip_out
);
    localparam int NPH = piot_pkg::PIOT_PHASES;
    localparam int SW = piot_pkg::PIOT_START_W;
    localparam int TW = piot_pkg::PIOT_THR_W;

    // byte-lane merge of a write into an existing word
    function automatic logic [31:0] mergeBytes(
        input logic [31:0] oldWord,
        input logic [31:0] newWord,
        input logic [3:0] strb
    );
        logic [31:0] res;
        res = oldWord;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[b*8 +: 8] = newWord[b*8 +: 8];
            end
        end
        return res;
    endfunction

    // word-aligned byte offset of a bus address
    function automatic logic [7:0] wordOffset(input logic [ADDR_W-1:0] addr);
        logic [7:0] ofs;
        ofs = 8'(addr);
        ofs[1:0] = 2'h0;
        return ofs;
    endfunction

    // settings
    piot_pkg::piot_mode_t mode_reg;
    piot_pkg::piot_mode_t mode_next;
    logic [SW-1:0] start_reg;
    logic [SW-1:0] start_next;

    // write channel state
    logic awHeld_reg;
    logic awHeld_next;
    logic [ADDR_W-1:0] awAddr_reg;
    logic [ADDR_W-1:0] awAddr_next;
    logic wHeld_reg;
    logic wHeld_next;
    logic [31:0] wData_reg;
    logic [31:0] wData_next;
    logic [3:0] wStrb_reg;
    logic [3:0] wStrb_next;
    logic bValid_reg;
    logic bValid_next;
    logic [1:0] bResp_reg;
    logic [1:0] bResp_next;

    // read channel state
    logic rValid_reg;
    logic rValid_next;
    logic [31:0] rData_reg;
    logic [31:0] rData_next;
    logic [1:0] rResp_reg;
    logic [1:0] rResp_next;

    // trip state
    logic [NPH-1:0] trip_reg;
    logic [NPH-1:0] trip_next;
    logic genTrip_reg;
    logic genTrip_next;
    logic [MEAS_W-1:0] meas_reg [NPH];
    logic [MEAS_W-1:0] meas_next [NPH];

    logic [MEAS_W-1:0] peakArr [NPH];
    logic [MEAS_W-1:0] fundArr [NPH];
    logic [MEAS_W-1:0] selArr [NPH];
    logic [NPH-1:0] overVec;
    logic [TW-1:0] activeThr;
    logic enabled;

    assign peakArr[0] = phase_a_peak_value;
    assign peakArr[1] = phase_b_peak_value;
    assign peakArr[2] = phase_c_peak_value;
    assign fundArr[0] = phase_a_fundamental_rms;
    assign fundArr[1] = phase_b_fundamental_rms;
    assign fundArr[2] = phase_c_fundamental_rms;

    // doubling is a shift, so the widened threshold never overflows
    assign activeThr = threshold_double_in ? {start_reg, 1'b0} : {1'b0, start_reg}; // R5
    assign enabled = (mode_reg != piot_pkg::PIOT_MODE_OFF) && !function_block_in; // R2 R4

    for (genvar p = 0; p < NPH; p++) begin : gPhase
        piot_phase_compare #(
            .MEAS_W(MEAS_W)
        ) uCmp (
            .mode(mode_reg),
            .peakValue(peakArr[p]),
            .fundValue(fundArr[p]),
            .threshold(activeThr),
            .selValue(selArr[p]),
            .overThreshold(overVec[p])
        );
    end

    // trip decision: one register stage, no further delay
    always_comb begin
        trip_next = trip_reg;
        for (int p = 0; p < NPH; p++) begin
            meas_next[p] = meas_reg[p];
        end
        if (sample_valid) begin
            trip_next = overVec; // R1 R6 R9
            for (int p = 0; p < NPH; p++) begin
                meas_next[p] = selArr[p];
            end
        end
        if (!enabled) begin
            trip_next = '0; // R2 R4
        end
        genTrip_next = |trip_next; // R7 R8
    end

    logic [ADDR_W-1:0] wrAddr;
    logic [31:0] wrData;
    logic [3:0] wrStrb;
    logic awTake;
    logic wTake;
    logic doWrite;
    logic arTake;
    logic [31:0] ctrlWord;
    logic [31:0] startWord;
    logic [31:0] statusWord;
    logic [31:0] mergedWord;
    localparam int PIOT_CTRL_MODE_W_L = piot_pkg::PIOT_CTRL_MODE_W;
    logic [PIOT_CTRL_MODE_W_L-1:0] newMode;


    assign s_axi_awready = !awHeld_reg && !bValid_reg;
    assign s_axi_wready = !wHeld_reg && !bValid_reg;
    assign s_axi_arready = !rValid_reg;
    assign awTake = s_axi_awvalid && s_axi_awready;
    assign wTake = s_axi_wvalid && s_axi_wready;
    assign arTake = s_axi_arvalid && s_axi_arready;
    assign wrAddr = awHeld_reg ? awAddr_reg : s_axi_awaddr;
    assign wrData = wHeld_reg ? wData_reg : s_axi_wdata;
    assign wrStrb = wHeld_reg ? wStrb_reg : s_axi_wstrb;
    assign doWrite = (awHeld_reg || awTake) && (wHeld_reg || wTake);

    always_comb begin
        ctrlWord = '0;
        ctrlWord[piot_pkg::PIOT_CTRL_MODE_LSB +: piot_pkg::PIOT_CTRL_MODE_W] = mode_reg;
        startWord = 32'(start_reg);
        statusWord = '0;
        statusWord[piot_pkg::PIOT_STAT_TRIP_LSB +: NPH] = trip_reg;
        statusWord[piot_pkg::PIOT_STAT_GEN_BIT] = genTrip_reg;
        statusWord[piot_pkg::PIOT_STAT_BLK_BIT] = function_block_in;
        statusWord[piot_pkg::PIOT_STAT_DBL_BIT] = threshold_double_in;
    end

    // register write path
    always_comb begin
        awHeld_next = awHeld_reg;
        awAddr_next = awAddr_reg;
        wHeld_next = wHeld_reg;
        wData_next = wData_reg;
        wStrb_next = wStrb_reg;
        bValid_next = bValid_reg;
        bResp_next = bResp_reg;
        mode_next = mode_reg;
        start_next = start_reg;
        mergedWord = '0;
        newMode = '0;
        if (bValid_reg && s_axi_bready) begin
            bValid_next = 1'b0;
        end
        if (awTake) begin
            awHeld_next = 1'b1;
            awAddr_next = s_axi_awaddr;
        end
        if (wTake) begin
            wHeld_next = 1'b1;
            wData_next = s_axi_wdata;
            wStrb_next = s_axi_wstrb;
        end
        if (doWrite) begin
            awHeld_next = 1'b0;
            wHeld_next = 1'b0;
            bValid_next = 1'b1;
            bResp_next = piot_pkg::PIOT_RESP_OKAY;
            case (wordOffset(wrAddr))
                piot_pkg::PIOT_OFS_CTRL: begin
                    mergedWord = mergeBytes(ctrlWord, wrData, wrStrb);
                    newMode = mergedWord[piot_pkg::PIOT_CTRL_MODE_LSB +: PIOT_CTRL_MODE_W_L];
                    // the spare encoding is refused so mode stays one of three
                    if (newMode == piot_pkg::PIOT_MODE_OFF || newMode == piot_pkg::PIOT_MODE_PEAK
                        || newMode == piot_pkg::PIOT_MODE_FUND) begin
                        mode_next = piot_pkg::piot_mode_t'(newMode); // R2
                    end else begin
                        bResp_next = piot_pkg::PIOT_RESP_SLVERR;
                    end
                end
                piot_pkg::PIOT_OFS_START: begin
                    mergedWord = mergeBytes(startWord, wrData, wrStrb);
                    if (mergedWord[31:SW] == '0 && mergedWord[SW-1:0] >= piot_pkg::PIOT_START_MIN
                        && mergedWord[SW-1:0] <= piot_pkg::PIOT_START_MAX) begin
                        start_next = mergedWord[SW-1:0]; // R3
                    end else begin
                        bResp_next = piot_pkg::PIOT_RESP_SLVERR;
                    end
                end
                piot_pkg::PIOT_OFS_STATUS,
                piot_pkg::PIOT_OFS_MEAS_A,
                piot_pkg::PIOT_OFS_MEAS_B,
                piot_pkg::PIOT_OFS_MEAS_C: begin
                    bResp_next = piot_pkg::PIOT_RESP_OKAY;
                end
                default: begin
                    bResp_next = piot_pkg::PIOT_RESP_SLVERR;
                end
            endcase
        end
    end

    // register read path
    always_comb begin
        rValid_next = rValid_reg;
        rData_next = rData_reg;
        rResp_next = rResp_reg;
        if (rValid_reg && s_axi_rready) begin
            rValid_next = 1'b0;
        end
        if (arTake) begin
            rValid_next = 1'b1;
            rResp_next = piot_pkg::PIOT_RESP_OKAY;
            case (wordOffset(s_axi_araddr))
                piot_pkg::PIOT_OFS_CTRL: begin
                    rData_next = ctrlWord;
                end
                piot_pkg::PIOT_OFS_START: begin
                    rData_next = startWord;
                end
                piot_pkg::PIOT_OFS_STATUS: begin
                    rData_next = statusWord;
                end
                piot_pkg::PIOT_OFS_MEAS_A: begin
                    rData_next = 32'(meas_reg[0]);
                end
                piot_pkg::PIOT_OFS_MEAS_B: begin
                    rData_next = 32'(meas_reg[1]);
                end
                piot_pkg::PIOT_OFS_MEAS_C: begin
                    rData_next = 32'(meas_reg[2]);
                end
                default: begin
                    rData_next = '0;
                    rResp_next = piot_pkg::PIOT_RESP_SLVERR;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            mode_reg <= piot_pkg::PIOT_MODE_OFF; // R2
            start_reg <= piot_pkg::PIOT_START_RESET; // R3
            awHeld_reg <= 1'b0;
            awAddr_reg <= '0;
            wHeld_reg <= 1'b0;
            wData_reg <= '0;
            wStrb_reg <= '0;
            bValid_reg <= 1'b0;
            bResp_reg <= piot_pkg::PIOT_RESP_OKAY;
            rValid_reg <= 1'b0;
            rData_reg <= '0;
            rResp_reg <= piot_pkg::PIOT_RESP_OKAY;
            trip_reg <= '0;
            genTrip_reg <= 1'b0;
            for (int p = 0; p < NPH; p++) begin
                meas_reg[p] <= '0;
            end
        end else begin
            mode_reg <= mode_next;
            start_reg <= start_next;
            awHeld_reg <= awHeld_next;
            awAddr_reg <= awAddr_next;
            wHeld_reg <= wHeld_next;
            wData_reg <= wData_next;
            wStrb_reg <= wStrb_next;
            bValid_reg <= bValid_next;
            bResp_reg <= bResp_next;
            rValid_reg <= rValid_next;
            rData_reg <= rData_next;
            rResp_reg <= rResp_next;
            trip_reg <= trip_next;
            genTrip_reg <= genTrip_next;
            for (int p = 0; p < NPH; p++) begin
                meas_reg[p] <= meas_next[p];
            end
        end
    end

    assign s_axi_bvalid = bValid_reg;
    assign s_axi_bresp = bResp_reg;
    assign s_axi_rvalid = rValid_reg;
    assign s_axi_rdata = rData_reg;
    assign s_axi_rresp = rResp_reg;
    assign phase_a_trip_out = trip_reg[0]; // R6
    assign phase_b_trip_out = trip_reg[1]; // R6
    assign phase_c_trip_out = trip_reg[2]; // R6
    assign general_trip_out = genTrip_reg; // R7
endmodule

// >>> piot_trip_props.sv
// assertions on the trip outputs of the overcurrent block
`timescale 1ns/1ps
module piot_trip_props #(
    parameter int MEAS_W = 16
) (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic sample_valid,
    input wire logic [MEAS_W-1:0] phase_a_peak_value,
    input wire logic [MEAS_W-1:0] phase_b_peak_value,
    input wire logic [MEAS_W-1:0] phase_c_peak_value,
    input wire logic [MEAS_W-1:0] phase_a_fundamental_rms,
    input wire logic [MEAS_W-1:0] phase_b_fundamental_rms,
    input wire logic [MEAS_W-1:0] phase_c_fundamental_rms,
    input wire logic function_block_in,
    input wire logic phase_a_trip_out,
    input wire logic phase_b_trip_out,
    input wire logic phase_c_trip_out,
    input wire logic general_trip_out
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    logic [2:0] phTrip;
    logic zeroIn;
    assign phTrip = {phase_c_trip_out, phase_b_trip_out, phase_a_trip_out};
    // zero can never exceed a threshold of at least 20
    assign zeroIn = sample_valid && ~|{phase_a_peak_value, phase_b_peak_value,
        phase_c_peak_value, phase_a_fundamental_rms, phase_b_fundamental_rms,
        phase_c_fundamental_rms};
    a_general_or: assert property (general_trip_out == (|phTrip))
        else $error("general trip differs from phase trips");
    a_general_src: assert property ($rose(general_trip_out) |-> $past(sample_valid))
        else $error("general trip rose without a sample");
    a_block_clear: assert property (function_block_in |=> phTrip == 3'h0)
        else $error("trip while blocked");
    a_rise_a: assert property ($rose(phase_a_trip_out) |->
        $past(sample_valid) && !$past(function_block_in))
        else $error("phase a trip rose without a sample");
    a_rise_b: assert property ($rose(phase_b_trip_out) |-> $past(sample_valid))
        else $error("phase b trip rose without a sample");
    a_rise_c: assert property ($rose(phase_c_trip_out) |-> $past(sample_valid))
        else $error("phase c trip rose without a sample");
    a_zero_drop: assert property (zeroIn |=> phTrip == 3'h0)
        else $error("trip held after a zero sample");
    a_reset_clear: assert property ($rose(rst_b) |-> phTrip == 3'h0 && !general_trip_out)
        else $error("trip present after reset");
    cover property ($rose(general_trip_out));
    cover property (phTrip == 3'h7);
    cover property (function_block_in && general_trip_out);
endmodule
bind piot_trip_top piot_trip_props #(.MEAS_W(MEAS_W)) i_piot_trip_props (
    .clk_sys(clk_sys), .rst_b(rst_b), .sample_valid(sample_valid),
    .phase_a_peak_value(phase_a_peak_value), .phase_b_peak_value(phase_b_peak_value),
    .phase_c_peak_value(phase_c_peak_value),
    .phase_a_fundamental_rms(phase_a_fundamental_rms),
    .phase_b_fundamental_rms(phase_b_fundamental_rms),
    .phase_c_fundamental_rms(phase_c_fundamental_rms),
    .function_block_in(function_block_in), .phase_a_trip_out(phase_a_trip_out),
    .phase_b_trip_out(phase_b_trip_out), .phase_c_trip_out(phase_c_trip_out),
    .general_trip_out(general_trip_out));

// >>> piot_meas_source.sv
// measurement source standing in for the peak and fourier stages
`timescale 1ns/1ps
module piot_meas_source #(
    parameter int MEAS_W = 16
) (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic req,
    input wire logic [3*MEAS_W-1:0] peakIn,
    input wire logic [3*MEAS_W-1:0] fundIn,
    output logic sample_valid,
    output logic [3*MEAS_W-1:0] peakOut,
    output logic [3*MEAS_W-1:0] fundOut
);
    logic validNext;
    logic [3*MEAS_W-1:0] peakNext;
    logic [3*MEAS_W-1:0] fundNext;
    always_comb begin
        validNext = req;
        // outside a sample the values toggle, so stale data cannot pass for valid
        peakNext = req ? peakIn : ~peakOut;
        fundNext = req ? fundIn : ~fundOut;
    end
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            sample_valid <= 1'b0;
            peakOut <= '0;
            fundOut <= '0;
        end else begin
            sample_valid <= validNext;
            peakOut <= peakNext;
            fundOut <= fundNext;
        end
    end
endmodule

// >>> phase_instant_overcurrent_trip_tb_top.sv
// testbench for the phase instantaneous overcurrent trip block
`timescale 1ns/1ps
module phase_instant_overcurrent_trip_tb_top;
    logic clk_sys = 1'b0;
    logic rst_b = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp, rsp;
    logic req = 0, blk = 0, dbl = 0, sv;
    logic [47:0] pkIn = '0, fdIn = '0, pk, fd;
    logic pa, pb, pc, gen;
    logic [31:0] d;
    logic [47:0] v;
    int err_total = 0, cmp_count = 0, cyc = 0;
    always #2.5 clk_sys = ~clk_sys;
    piot_meas_source i_piot_meas_source (.clk_sys(clk_sys), .rst_b(rst_b), .req(req),
        .peakIn(pkIn), .fundIn(fdIn), .sample_valid(sv), .peakOut(pk), .fundOut(fd));
    piot_trip_top i_piot_trip_top (.clk_sys(clk_sys), .rst_b(rst_b),
        .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .sample_valid(sv), .phase_a_peak_value(pk[15:0]),
        .phase_b_peak_value(pk[31:16]), .phase_c_peak_value(pk[47:32]),
        .phase_a_fundamental_rms(fd[15:0]), .phase_b_fundamental_rms(fd[31:16]),
        .phase_c_fundamental_rms(fd[47:32]), .function_block_in(blk),
        .threshold_double_in(dbl), .phase_a_trip_out(pa), .phase_b_trip_out(pb),
        .phase_c_trip_out(pc), .general_trip_out(gen));
    task automatic conclude();
        $display("mismatches %0d comparisons %0d", err_total, cmp_count);
        if (err_total == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // handshakes are judged at the falling edge, where nothing moves until the next rise
    task automatic wr(input logic [7:0] a, input logic [31:0] dat, output logic [1:0] r);
        logic hA, hW, hB;
        @(posedge clk_sys);
        awaddr <= a;
        wdata <= dat;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(negedge clk_sys);
            hA = awvalid && awready;
            hW = wvalid && wready;
            hB = bvalid && bready;
            r = bresp;
            @(posedge clk_sys);
            if (hA) awvalid <= 1'b0;
            if (hW) wvalid <= 1'b0;
            if (hB) bready <= 1'b0;
        end while (!hB);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] dat, output logic [1:0] r);
        logic hA, hR;
        @(posedge clk_sys);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(negedge clk_sys);
            hA = arvalid && arready;
            hR = rvalid && rready;
            dat = rdata;
            r = rresp;
            @(posedge clk_sys);
            if (hA) arvalid <= 1'b0;
            if (hR) rready <= 1'b0;
        end while (!hR);
    endtask
    // one sample through the source, then the trips one cycle after it is taken
    task automatic smp(input logic [47:0] p, input logic [47:0] f, input logic [3:0] exp);
        @(posedge clk_sys);
        req <= 1'b1;
        pkIn <= p;
        fdIn <= f;
        @(posedge clk_sys);
        req <= 1'b0;
        repeat (2) @(posedge clk_sys);
        #1;
        chk({28'h0, gen, pc, pb, pa}, {28'h0, exp});
    endtask
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 5000) begin
            err_total++;
            conclude();
        end
    end
    initial begin
        repeat (6) @(posedge clk_sys);
        rst_b <= 1'b1;
        rd(8'h00, d, rsp);
        chk(d, 32'h0);
        rd(8'h04, d, rsp);
        chk(d, 32'h0C8);
        smp({3{16'h0BB8}}, {3{16'h0BB8}}, 4'h0);
        wr(8'h00, 32'h1, rsp);
        chk({30'h0, rsp}, {30'h0, piot_pkg::PIOT_RESP_OKAY});
        for (int i = 0; i < 3; i++) begin
            v = {3{16'h00C8}};
            v[i*16+:16] = 16'h00C9;
            smp(v, '0, 4'h8 | (4'h1 << i));
        end
        smp({3{16'h00C8}}, '0, 4'h0);
        @(posedge clk_sys) dbl <= 1'b1;
        smp({3{16'h0190}}, '0, 4'h0);
        smp({3{16'h0191}}, '0, 4'hF);
        @(posedge clk_sys) dbl <= 1'b0;
        smp({3{16'h0191}}, '0, 4'hF);
        @(posedge clk_sys) blk <= 1'b1;
        repeat (2) @(posedge clk_sys);
        #1;
        chk({28'h0, gen, pc, pb, pa}, 32'h0);
        smp({3{16'h0191}}, '0, 4'h0);
        @(posedge clk_sys) blk <= 1'b0;
        wr(8'h00, 32'h2, rsp);
        chk({30'h0, rsp}, {30'h0, piot_pkg::PIOT_RESP_OKAY});
        smp({3{16'h0FFF}}, {3{16'h00C8}}, 4'h0);
        smp('0, {3{16'h00C9}}, 4'hF);
        smp('0, '0, 4'h0);
        wr(8'h04, 32'h13, rsp);
        chk({30'h0, rsp}, {30'h0, piot_pkg::PIOT_RESP_SLVERR});
        wr(8'h04, 32'hBB9, rsp);
        chk({30'h0, rsp}, {30'h0, piot_pkg::PIOT_RESP_SLVERR});
        wr(8'h04, 32'hBB8, rsp);
        chk({30'h0, rsp}, {30'h0, piot_pkg::PIOT_RESP_OKAY});
        rd(8'h04, d, rsp);
        chk(d, 32'hBB8);
        wr(8'h04, 32'h14, rsp);
        chk({30'h0, rsp}, {30'h0, piot_pkg::PIOT_RESP_OKAY});
        smp('0, {16'h0014, 16'h0015, 16'h0014}, 4'hA);
        rd(8'h08, d, rsp);
        chk(d, 32'h0000000A);
        rd(8'h10, d, rsp);
        chk(d, 32'h00000015);
        wr(8'h00, 32'h3, rsp);
        chk({30'h0, rsp}, {30'h0, piot_pkg::PIOT_RESP_SLVERR});
        rd(8'h00, d, rsp);
        chk(d, 32'h2);
        rd(8'h40, d, rsp);
        chk(d, 32'h0);
        chk({30'h0, rsp}, {30'h0, piot_pkg::PIOT_RESP_SLVERR});
        wr(8'h00, 32'h0, rsp);
        #1;
        chk({28'h0, gen, pc, pb, pa}, 32'h0);
        conclude();
    end
endmodule
